// >>> rtl/pwr_seq.sv
// Power-down wake, power-on reset and boot-mode selection
// Assumes supply comparators arrive as async levels; core hooks are same-clock
`timescale 1ns/10ps
`include "pwr_seq_regs.svh"

// Functional notes
// - An external reset pin during power-down resets all registers, fetch starts after release. The code keeps the IRQ status bits (sts_r) through it.
// - Supply removal and return loads defaults and starts at the reset vector. The code keeps the IRQ status bits (sts_r) through it.
// - An interval-counter interrupt ends power-down and is serviced.
// - After a wake service routine returns, execution resumes after the power-down instruction.
// - A serial-peripheral interrupt wakes only when its wake enable was set beforehand.
// - An external interrupt 0 event wakes only when its wake enable was set beforehand.
// - Reset is held while supply is below 2.45 V and released 128 ms after it rises above.
// - On supply fall, reset stays asserted until supply drops below 1 V.
// - Boot-select high at reset release selects serial download mode.
// - Boot-select low at reset release selects normal run of the stored program.
// - Serial debug shares the download mode and its entry condition.
// - Single-pin emulation is reached through the boot-select pin held high. The code also needs the emulation request pin high, else it picks download.
// - Bit 0 of power control enters idle, bit 1 enters full power-down.
module pwr_seq
	import pwr_seq_pkg::*;
#(
	parameter int POR_CYCLES = `POR_HOLD_CYCLES
)(
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	// Pins and supply comparators
	input  wire logic        reset_pin_in,
	input  wire logic        boot_select_pin_in,
	input  wire logic        emu_request_in,
	input  wire logic        supply_above_2v45_in,
	input  wire logic        supply_above_1v_in,
	input  wire logic        external_irq0_input,
	// Core hooks
	input  wire logic        interval_counter_irq_in,
	input  wire logic        serial_periph_irq_in,
	input  wire logic        any_enabled_irq_in,
	input  wire logic        return_from_isr_in,
	input  wire logic [15:0] pd_instr_next_pc_in,
	// Outputs
	output logic             core_reset_out,
	output logic             core_clk_en_out,
	output logic             pll_run_out,
	output logic             service_interval_out,
	output logic             service_serial_out,
	output logic             service_ext0_out,
	output logic [15:0]      resume_pc_out,
	output logic             resume_valid_out,
	output logic [1:0]       boot_mode_out,
	output logic             irq_out
);

	logic       rst_pin_s;
	logic       boot_s;
	logic       emu_s;
	logic       above_hi_s;
	logic       above_lo_s;
	logic       ext0_s;

	pin_sync3 #(
		.WIDTH     (5),
		.RST_LEVEL (1'b0)
	) i_pin_sync3 (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.pin_in     ({reset_pin_in, boot_select_pin_in, emu_request_in,
		              supply_above_2v45_in, supply_above_1v_in}),
		.level_out  ({rst_pin_s, boot_s, emu_s, above_hi_s, above_lo_s})
	);

	// Interrupt pin idles high; reset high so no false fall follows reset
	pin_sync3 #(
		.WIDTH     (1),
		.RST_LEVEL (1'b1)
	) i_pin_sync3_irq (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.pin_in     (external_irq0_input),
		.level_out  (ext0_s)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	pwr_state_t  state_r,      state_nxt;
	logic [31:0] por_cnt_r,    por_cnt_nxt;
	logic [7:0]  pctl_r,       pctl_nxt;
	logic [`EV_COUNT-1:0] sts_r, sts_nxt;
	logic [`EV_COUNT-1:0] ien_r, ien_nxt;
	logic [15:0] ret_pc_r,     ret_pc_nxt;
	logic        ret_pend_r,   ret_pend_nxt;
	logic        resume_r,     resume_nxt;
	logic [2:0]  svc_r,        svc_nxt;
	logic [1:0]  boot_r,       boot_nxt;
	logic        ext0_prev_r;
	logic        ack_r,        ack_nxt;
	logic [31:0] rdata_r,      rdata_nxt;
	logic        in_reset;
	logic [`EV_COUNT-1:0] ev;
	logic        wr_hit;
	logic        rd_hit;
	logic        ext0_fall;

	// Write lands only at the edge where waitrequest is seen low
	assign wr_hit    = avs_write_in && ack_r;
	assign rd_hit    = avs_read_in && !ack_r;
	assign ext0_fall = ext0_prev_r && !ext0_s;
	assign in_reset  = (state_r == ST_POR_HOLD) || (state_r == ST_POR_WAIT)
	                || (state_r == ST_EXT_RESET);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb
	begin
		state_nxt   = state_r;
		por_cnt_nxt = por_cnt_r;
		svc_nxt     = 3'b000;
		ev          = '0;
		boot_nxt    = boot_r;
		case (state_r)
			ST_POR_HOLD:
			begin
				por_cnt_nxt = '0;
				if (above_hi_s)
					state_nxt = ST_POR_WAIT;
			end
			ST_POR_WAIT:
			begin
				if (!above_hi_s)
					state_nxt = ST_POR_HOLD;
				else if (por_cnt_r >= 32'(POR_CYCLES - 1))
				begin
					state_nxt = ST_RUN;
					ev[`EV_POR_RELEASE] = 1'b1;
					if (boot_s && emu_s)
						boot_nxt = BOOT_EMULATE;
					else if (boot_s)
						boot_nxt = BOOT_DOWNLOAD;
					else
						boot_nxt = BOOT_NORMAL;
				end
				else
					por_cnt_nxt = por_cnt_r + 32'd1;
			end
			ST_EXT_RESET:
			begin
				if (!rst_pin_s)
				begin
					state_nxt = ST_RUN;
					if (boot_s && emu_s)
						boot_nxt = BOOT_EMULATE;
					else if (boot_s)
						boot_nxt = BOOT_DOWNLOAD;
					else
						boot_nxt = BOOT_NORMAL;
				end
			end
			ST_RUN:
			begin
				if (pctl_r[`PC_POWERDOWN_BIT])
					state_nxt = ST_POWERDOWN;
				else if (pctl_r[`PC_IDLE_BIT])
					state_nxt = ST_IDLE;
			end
			ST_IDLE:
			begin
				if (any_enabled_irq_in)
					state_nxt = ST_RUN;
			end
			ST_POWERDOWN:
			begin
				if (rst_pin_s)
				begin
					state_nxt = ST_EXT_RESET;
					ev[`EV_WAKE_RESET] = 1'b1;
				end
				else if (interval_counter_irq_in)
				begin
					state_nxt = ST_RUN;
					svc_nxt[0] = 1'b1;
					ev[`EV_WAKE_INTERVAL] = 1'b1;
				end
				else if (serial_periph_irq_in && pctl_r[`PC_SERIAL_WAKE_BIT])
				begin
					state_nxt = ST_RUN;
					svc_nxt[1] = 1'b1;
					ev[`EV_WAKE_SERIAL] = 1'b1;
				end
				else if (ext0_fall && pctl_r[`PC_EXT0_WAKE_BIT])
				begin
					state_nxt = ST_RUN;
					svc_nxt[2] = 1'b1;
					ev[`EV_WAKE_EXT0] = 1'b1;
				end
			end
			default:
				state_nxt = ST_POR_HOLD;
		endcase
		if (!above_lo_s || (!above_hi_s && state_r != ST_POR_WAIT))
		begin
			if (!above_hi_s)
				state_nxt = ST_POR_HOLD;
		end
		else if (rst_pin_s && state_r != ST_POR_HOLD && state_r != ST_POR_WAIT)
			state_nxt = ST_EXT_RESET;
	end

	// ----------------------------------------
	// Registers and return path
	// ----------------------------------------
	always_comb
	begin
		pctl_nxt     = pctl_r;
		ien_nxt      = ien_r;
		ret_pc_nxt   = ret_pc_r;
		ret_pend_nxt = ret_pend_r;
		resume_nxt   = 1'b0;
		ack_nxt      = (avs_read_in || avs_write_in) && !ack_r;
		rdata_nxt    = rdata_r;
		sts_nxt      = sts_r;
		if (wr_hit && avs_address_in == `OFS_IRQ_CLEAR)
			sts_nxt = sts_r & ~avs_writedata_in[`EV_COUNT-1:0];
		sts_nxt = sts_nxt | ev;
		if (wr_hit && avs_address_in == `OFS_POWER_CONTROL)
			pctl_nxt = avs_writedata_in[7:0];
		if (wr_hit && avs_address_in == `OFS_IRQ_ENABLE)
			ien_nxt = avs_writedata_in[`EV_COUNT-1:0];
		if (state_r == ST_RUN && pctl_r[`PC_POWERDOWN_BIT])
			ret_pc_nxt = pd_instr_next_pc_in;
		if (state_r == ST_POWERDOWN && state_nxt == ST_RUN)
		begin
			pctl_nxt[`PC_POWERDOWN_BIT] = 1'b0;
			ret_pend_nxt = 1'b1;
		end
		if (state_r == ST_IDLE && state_nxt == ST_RUN)
			pctl_nxt[`PC_IDLE_BIT] = 1'b0;
		if (ret_pend_r && return_from_isr_in)
		begin
			ret_pend_nxt = 1'b0;
			resume_nxt   = 1'b1;
		end
		if (rd_hit)
		begin
			case (avs_address_in)
				`OFS_POWER_CONTROL: rdata_nxt = {24'h00_0000, pctl_r};
				`OFS_IRQ_STATUS:    rdata_nxt = {27'h000_0000, sts_r};
				`OFS_IRQ_ENABLE:    rdata_nxt = {27'h000_0000, ien_r};
				`OFS_STATE:         rdata_nxt = {27'h000_0000, boot_r, state_r};
				`OFS_RETURN_ADDR:   rdata_nxt = {16'h0000, ret_pc_r};
				default:            rdata_nxt = 32'h0000_0000;
			endcase
		end
		if (in_reset)
		begin
			pctl_nxt     = `PC_RESET_VALUE;
			ien_nxt      = '0;
			ret_pend_nxt = 1'b0;
			ret_pc_nxt   = `RESET_VECTOR;
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			state_r     <= ST_POR_HOLD;
			por_cnt_r   <= 32'h0000_0000;
			pctl_r      <= `PC_RESET_VALUE;
			sts_r       <= '0;
			ien_r       <= '0;
			ret_pc_r    <= `RESET_VECTOR;
			ret_pend_r  <= 1'b0;
			resume_r    <= 1'b0;
			svc_r       <= 3'b000;
			boot_r      <= BOOT_NORMAL;
			ext0_prev_r <= 1'b1;
			ack_r       <= 1'b0;
			rdata_r     <= 32'h0000_0000;
		end
		else
		begin
			state_r     <= state_nxt;
			por_cnt_r   <= por_cnt_nxt;
			pctl_r      <= pctl_nxt;
			sts_r       <= sts_nxt;
			ien_r       <= ien_nxt;
			ret_pc_r    <= ret_pc_nxt;
			ret_pend_r  <= ret_pend_nxt;
			resume_r    <= resume_nxt;
			svc_r       <= svc_nxt;
			boot_r      <= boot_nxt;
			ext0_prev_r <= ext0_s;
			ack_r       <= ack_nxt;
			rdata_r     <= rdata_nxt;
		end
	end

	// Outputs registered; waitrequest idles high, low one cycle per access
	logic        core_rst_r;
	logic        clk_en_r;
	logic        pll_r;
	logic        irq_r;
	logic        wait_r;
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			core_rst_r <= 1'b1;
			clk_en_r   <= 1'b0;
			pll_r      <= 1'b0;
			irq_r      <= 1'b0;
			wait_r     <= 1'b1;
		end
		else
		begin
			core_rst_r <= (state_nxt == ST_POR_HOLD) || (state_nxt == ST_POR_WAIT)
			           || (state_nxt == ST_EXT_RESET);
			clk_en_r   <= (state_nxt == ST_RUN);
			pll_r      <= (state_nxt != ST_POWERDOWN);
			irq_r      <= |(sts_nxt & ien_nxt);
			wait_r     <= !ack_nxt;
		end
	end

	assign core_reset_out       = core_rst_r;
	assign core_clk_en_out      = clk_en_r;
	assign pll_run_out          = pll_r;
	assign service_interval_out = svc_r[0];
	assign service_serial_out   = svc_r[1];
	assign service_ext0_out     = svc_r[2];
	assign resume_pc_out        = ret_pc_r;
	assign resume_valid_out     = resume_r;
	assign boot_mode_out        = boot_r;
	assign irq_out              = irq_r;
	assign avs_readdata_out     = rdata_r;
	assign avs_waitrequest_out  = wait_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_pd_reset;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(state_r == ST_POWERDOWN && rst_pin_s && above_hi_s) |=> core_reset_out;
	endproperty
	a_pd_reset: assert property (p_pd_reset) else $error("reset pin ignored");

	property p_tic_wake;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(state_r == ST_POWERDOWN && !rst_pin_s && interval_counter_irq_in && above_hi_s)
		|=> service_interval_out && core_clk_en_out;
	endproperty
	a_tic_wake: assert property (p_tic_wake) else $error("interval wake missed");

	property p_resume;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(ret_pend_r && return_from_isr_in && !in_reset) |=> resume_valid_out;
	endproperty
	a_resume: assert property (p_resume) else $error("no resume");

	property p_serial_gate;
		@(posedge mclk_in) disable iff (sys_rst_in)
		service_serial_out |-> $past(pctl_r[`PC_SERIAL_WAKE_BIT]);
	endproperty
	a_serial_gate: assert property (p_serial_gate) else $error("serial wake ungated");

	property p_ext0_gate;
		@(posedge mclk_in) disable iff (sys_rst_in)
		service_ext0_out |-> $past(pctl_r[`PC_EXT0_WAKE_BIT]);
	endproperty
	a_ext0_gate: assert property (p_ext0_gate) else $error("ext0 wake ungated");

	property p_por_hold;
		@(posedge mclk_in) disable iff (sys_rst_in)
		!above_hi_s |=> core_reset_out;
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("reset released low");

	property p_por_release;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(state_r == ST_POR_WAIT && state_nxt == ST_RUN) |-> por_cnt_r == 32'(POR_CYCLES - 1);
	endproperty
	a_por_release: assert property (p_por_release) else $error("early release");

	property p_boot_dl;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(state_r == ST_EXT_RESET && state_nxt == ST_RUN && boot_s && !emu_s)
		|=> boot_mode_out == BOOT_DOWNLOAD;
	endproperty
	a_boot_dl: assert property (p_boot_dl) else $error("download not chosen");

	property p_gated_off;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(state_r == ST_POWERDOWN && !pctl_r[`PC_SERIAL_WAKE_BIT]
		 && !pctl_r[`PC_EXT0_WAKE_BIT] && !interval_counter_irq_in && !rst_pin_s)
		|=> !service_serial_out && !service_ext0_out;
	endproperty
	a_gated_off: assert property (p_gated_off) else $error("disabled wake fired");

endmodule : pwr_seq

// >>> rtl/pwr_seq_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 10 MHz system clock and a word-addressed Avalon-MM slave
`ifndef PWR_SEQ_REGS_SVH
`define PWR_SEQ_REGS_SVH

// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define OFS_POWER_CONTROL   4'h0
`define OFS_IRQ_STATUS     4'h1
`define OFS_IRQ_CLEAR      4'h2
`define OFS_IRQ_ENABLE     4'h3
`define OFS_STATE          4'h4
`define OFS_RETURN_ADDR    4'h5
`define OFS_WAKE_ACK       4'h6

// ----------------------------------------
// Power control fields
// ----------------------------------------
`define PC_IDLE_BIT        0
`define PC_POWERDOWN_BIT   1
`define PC_SERIAL_WAKE_BIT 2
`define PC_EXT0_WAKE_BIT   3
`define PC_RESET_VALUE     8'h00

// ----------------------------------------
// Status bits
// ----------------------------------------
`define EV_WAKE_RESET      0
`define EV_WAKE_INTERVAL   1
`define EV_WAKE_SERIAL     2
`define EV_WAKE_EXT0       3
`define EV_POR_RELEASE     4
`define EV_COUNT           5

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ             10000000
`define POR_HOLD_MS        128
`define POR_HOLD_CYCLES    ((`CLK_HZ / 1000) * `POR_HOLD_MS)
`define RESET_VECTOR       16'h0000

`endif

// >>> rtl/pwr_seq_pkg.sv
// Types shared by the power sequencer files
// Assumes the constants header is compiled alongside
package pwr_seq_pkg;

	typedef enum logic [2:0]
	{
		ST_POR_HOLD  = 3'b000,
		ST_POR_WAIT  = 3'b001,
		ST_RUN       = 3'b011,
		ST_POWERDOWN = 3'b010,
		ST_IDLE      = 3'b110,
		ST_EXT_RESET = 3'b100
	} pwr_state_t;

	typedef enum logic [1:0]
	{
		BOOT_NORMAL   = 2'b00,
		BOOT_DOWNLOAD = 2'b01,
		BOOT_EMULATE  = 2'b11
	} boot_mode_t;

endpackage : pwr_seq_pkg

// >>> rtl/pin_sync3.sv
// Three-stage synchroniser with agreement filter for external pins
// Assumes pins are asynchronous to mclk_in
`timescale 1ns/10ps
module pin_sync3 #(
	parameter int WIDTH     = 1,
	parameter bit RST_LEVEL = 1'b0
)(
	// Clock and reset
	input  wire logic             mclk_in,
	input  wire logic             sys_rst_in,
	// Pins
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] lvl_r;
	logic [WIDTH-1:0] lvl_nxt;

	// ----------------------------------------
	// Agreement of stages two and three
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			always_comb
			begin
				lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
			end
		end
	endgenerate

	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			s1_r  <= {WIDTH{RST_LEVEL}};
			s2_r  <= {WIDTH{RST_LEVEL}};
			s3_r  <= {WIDTH{RST_LEVEL}};
			lvl_r <= {WIDTH{RST_LEVEL}};
		end
		else
		begin
			s1_r  <= pin_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign level_out = lvl_r;

endmodule : pin_sync3

// >>> testbench/pwr_partner.sv
// Far-side model: reset pin, boot strap, supply comparators and core hooks
// Assumes its tasks are called by the bench between clock edges of mclk_in
`timescale 1ns/10ps
module pwr_partner (
	// Clock
	input  wire logic        mclk_in,
	// Pins and supply
	output logic             reset_pin_out,
	output logic             boot_select_out,
	output logic             emu_request_out,
	output logic             supply_hi_out,
	output logic             supply_lo_out,
	output logic             ext_irq0_out,
	// Core hooks
	output logic             interval_irq_out,
	output logic             serial_irq_out,
	output logic             any_irq_out,
	output logic             isr_return_out,
	output logic [15:0]      next_pc_out
);
	// ----------------------------------------
	// Power-up levels
	// ----------------------------------------
	initial
	begin
		reset_pin_out    = 1'b0;
		boot_select_out  = 1'b0;
		emu_request_out  = 1'b0;
		supply_hi_out    = 1'b0;
		supply_lo_out    = 1'b0;
		ext_irq0_out     = 1'b1;
		interval_irq_out = 1'b0;
		serial_irq_out   = 1'b0;
		any_irq_out      = 1'b0;
		isr_return_out   = 1'b0;
		next_pc_out      = 16'h1234;
	end

	// ----------------------------------------
	// Stimulus tasks
	// ----------------------------------------
	task set_levels(input logic boot, input logic emu, input logic hi, input logic lo);
		@(posedge mclk_in);
		boot_select_out <= boot;
		emu_request_out <= emu;
		supply_hi_out   <= hi;
		supply_lo_out   <= lo;
	endtask : set_levels

	task drive(input int sel, input logic v);
		case (sel)
			0: interval_irq_out <= v;
			1: serial_irq_out <= v;
			2: ext_irq0_out <= !v;
			3: reset_pin_out <= v;
			4: isr_return_out <= v;
			default: any_irq_out <= v;
		endcase
	endtask : drive

	// Low only when commanded, so no fall near power-down entry
	task pulse(input int sel, input int len);
		@(posedge mclk_in);
		drive(sel, 1'b1);
		repeat (len) @(posedge mclk_in);
		drive(sel, 1'b0);
	endtask : pulse
endmodule : pwr_partner

// >>> testbench/pwr_seq_tb.sv
// Self-checking bench for the power sequencer
// Assumes the far-side model and a shortened power-on hold of 20 cycles
`timescale 1ns/10ps
`include "pwr_seq_regs.svh"
module pwr_seq_tb
	import pwr_seq_pkg::*;
();
	logic        mclk_in, sys_rst_in, avs_read, avs_write;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, rd, avs_readdata;
	logic        wreq, rst_pin, boot, emu, s_hi, s_lo, ext0, interval_counter, ser, anyi, return_from_isr;
	logic        core_rst, clk_en, pll, sv_int, sv_ser, sv_ext, res_v, irq;
	logic [15:0] next_pc, res_pc, last_pc;
	logic [1:0]  boot_mode;
	int          miscompares, cmp_count, n_int, n_ser, n_ext, n_res;

	pwr_seq #(.POR_CYCLES(20)) i_pwr_seq (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
		.avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
		.avs_waitrequest_out(wreq), .reset_pin_in(rst_pin), .boot_select_pin_in(boot),
		.emu_request_in(emu), .supply_above_2v45_in(s_hi), .supply_above_1v_in(s_lo),
		.external_irq0_input(ext0), .interval_counter_irq_in(interval_counter),
		.serial_periph_irq_in(ser), .any_enabled_irq_in(anyi), .return_from_isr_in(return_from_isr),
		.pd_instr_next_pc_in(next_pc), .core_reset_out(core_rst), .core_clk_en_out(clk_en),
		.pll_run_out(pll), .service_interval_out(sv_int), .service_serial_out(sv_ser),
		.service_ext0_out(sv_ext), .resume_pc_out(res_pc), .resume_valid_out(res_v),
		.boot_mode_out(boot_mode), .irq_out(irq));

	pwr_partner i_pwr_partner (.mclk_in(mclk_in), .reset_pin_out(rst_pin),
		.boot_select_out(boot), .emu_request_out(emu), .supply_hi_out(s_hi),
		.supply_lo_out(s_lo), .ext_irq0_out(ext0), .interval_irq_out(interval_counter),
		.serial_irq_out(ser), .any_irq_out(anyi), .isr_return_out(return_from_isr),
		.next_pc_out(next_pc));

	// ----------------------------------------
	// Clock and pulse counters
	// ----------------------------------------
	initial
	begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end

	// Service pulses last one cycle, so count them rather than poll
	always @(posedge mclk_in)
	begin
		if (sv_int === 1'b1) n_int++;
		if (sv_ser === 1'b1) n_ser++;
		if (sv_ext === 1'b1) n_ext++;
		if (res_v === 1'b1) n_res++;
		if (res_v === 1'b1) last_pc = res_pc;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk_in);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do
			@(posedge mclk_in);
		while (wreq !== 1'b0 && ++n < 20);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		check("bus answer", 32'h0, (n < 20) ? 32'h0 : 32'h1);
	endtask : bus

	task rd_check(input string what, input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(what, exp, rd);
	endtask : rd_check

	task wait_core_run(input int lim);
		int n;
		n = 0;
		while (core_rst !== 1'b0 && n++ < lim) @(posedge mclk_in);
		check("core reset released", 32'h0, {31'h0, core_rst});
	endtask : wait_core_run

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_por;
		repeat (30) @(posedge mclk_in);
		check("reset held low supply", 32'h1, {31'h0, core_rst});
		i_pwr_partner.set_levels(1'b0, 1'b0, 1'b1, 1'b1);
		repeat (15) @(posedge mclk_in);
		check("reset within hold", 32'h1, {31'h0, core_rst});
		wait_core_run(60);
		check("boot normal", BOOT_NORMAL, {30'h0, boot_mode});
		rd_check("status after power-on", `OFS_IRQ_STATUS, 32'h10);
		rd_check("state word", `OFS_STATE, {27'h0, BOOT_NORMAL, ST_RUN});
		$display("test por done");
	endtask : t_por

	task t_irq;
		rd_check("enable reset value", `OFS_IRQ_ENABLE, 32'h0);
		bus(1'b1, `OFS_IRQ_ENABLE, 32'h10);
		repeat (3) @(posedge mclk_in);
		check("irq raised", 32'h1, {31'h0, irq});
		rd_check("clear reads zero", `OFS_IRQ_CLEAR, 32'h0);
		bus(1'b1, `OFS_IRQ_CLEAR, 32'h10);
		repeat (3) @(posedge mclk_in);
		check("irq cleared", 32'h0, {31'h0, irq});
		rd_check("status cleared", `OFS_IRQ_STATUS, 32'h0);
		rd_check("unmapped", 4'hF, 32'h0);
		bus(1'b1, `OFS_IRQ_ENABLE, 32'h0);
		$display("test irq done");
	endtask : t_irq

	task t_interval;
		int n0;
		bus(1'b1, `OFS_POWER_CONTROL, 32'h1);
		repeat (4) @(posedge mclk_in);
		check("idle stops core", 32'h0, {31'h0, clk_en});
		i_pwr_partner.pulse(5, 1);
		repeat (4) @(posedge mclk_in);
		check("idle exit", 32'h1, {31'h0, clk_en});
		n0 = n_res;
		bus(1'b1, `OFS_POWER_CONTROL, 32'h2);
		repeat (4) @(posedge mclk_in);
		check("pll off in power-down", 32'h0, {31'h0, pll});
		i_pwr_partner.pulse(0, 1);
		repeat (6) @(posedge mclk_in);
		check("interval serviced", 32'h1, n_int);
		check("pll back", 32'h1, {31'h0, pll});
		rd_check("power bit self-clear", `OFS_POWER_CONTROL, 32'h0);
		rd_check("return address", `OFS_RETURN_ADDR, 32'h1234);
		i_pwr_partner.pulse(4, 1);
		repeat (4) @(posedge mclk_in);
		check("resume once", 32'h1, n_res - n0);
		check("resume address", 32'h1234, {16'h0, last_pc});
		$display("test interval done");
	endtask : t_interval

	task t_serial;
		bus(1'b1, `OFS_POWER_CONTROL, 32'h2);
		i_pwr_partner.pulse(1, 1);
		repeat (8) @(posedge mclk_in);
		check("serial ignored", 32'h0, n_ser);
		check("still powered down", 32'h0, {31'h0, pll});
		i_pwr_partner.pulse(0, 1);
		i_pwr_partner.pulse(4, 1);
		bus(1'b1, `OFS_POWER_CONTROL, 32'h4);
		bus(1'b1, `OFS_POWER_CONTROL, 32'h6);
		repeat (4) @(posedge mclk_in);
		i_pwr_partner.pulse(1, 1);
		repeat (8) @(posedge mclk_in);
		check("serial wake", 32'h1, n_ser);
		rd_check("enable kept", `OFS_POWER_CONTROL, 32'h4);
		i_pwr_partner.pulse(4, 1);
		$display("test serial done");
	endtask : t_serial

	task t_ext0;
		bus(1'b1, `OFS_POWER_CONTROL, 32'h8);
		bus(1'b1, `OFS_POWER_CONTROL, 32'hA);
		repeat (6) @(posedge mclk_in);
		i_pwr_partner.pulse(2, 4);
		repeat (10) @(posedge mclk_in);
		check("ext0 wake", 32'h1, n_ext);
		check("pll after ext0", 32'h1, {31'h0, pll});
		i_pwr_partner.pulse(4, 1);
		$display("test ext0 done");
	endtask : t_ext0

	task t_boot;
		logic     bt[3] = '{1'b1, 1'b1, 1'b0};
		logic     em[3] = '{1'b0, 1'b1, 1'b0};
		boot_mode_t exp[3] = '{BOOT_DOWNLOAD, BOOT_EMULATE, BOOT_NORMAL};
		for (int i = 0; i < 3; i++)
		begin
			bus(1'b1, `OFS_POWER_CONTROL, 32'hE);
			i_pwr_partner.set_levels(bt[i], em[i], 1'b1, 1'b1);
			i_pwr_partner.pulse(3, 8);
			check("reset pin holds core", 32'h1, {31'h0, core_rst});
			wait_core_run(60);
			check("boot mode", exp[i], {30'h0, boot_mode});
			rd_check("defaults after pin", `OFS_POWER_CONTROL, 32'h0);
		end
		i_pwr_partner.set_levels(1'b0, 1'b0, 1'b1, 1'b1);
		$display("test boot done");
	endtask : t_boot

	task t_supply;
		bus(1'b1, `OFS_POWER_CONTROL, 32'hC);
		i_pwr_partner.set_levels(1'b0, 1'b0, 1'b0, 1'b1);
		repeat (18) @(posedge mclk_in);
		check("reset on supply fall", 32'h1, {31'h0, core_rst});
		i_pwr_partner.set_levels(1'b0, 1'b0, 1'b0, 1'b0);
		repeat (5) @(posedge mclk_in);
		i_pwr_partner.set_levels(1'b0, 1'b0, 1'b1, 1'b1);
		wait_core_run(80);
		rd_check("defaults after cycle", `OFS_POWER_CONTROL, 32'h0);
		$display("test supply done");
	endtask : t_supply

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	initial
	begin
		sys_rst_in = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		repeat (4) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		t_por();
		t_irq();
		t_interval();
		t_serial();
		t_ext0();
		t_boot();
		t_supply();
		finish_test();
	end

	// Whole run needs well under 2000 cycles
	initial
	begin
		repeat (6000) @(posedge mclk_in);
		miscompares++;
		finish_test();
	end
endmodule : pwr_seq_tb
